// >>> src/mft_router.sv
// multifunction terminal router: routing field, loader strap, speaker and ring outputs
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - terminal 0 offers int A, gpio0, led, zv, pwm, wake, irq
// - terminal 1 offers int B, gpio1, led, zv, pwm, wake, irq
// - strap low at global release: terminal 1 is data
// - bus reset release starts eeprom default load
// - terminal 2 adds ring and low-power status roles
// - terminal 3 irq or serialized irq, serialized default
// - terminal 4 adds bus lock, ring, low power
// - strap low at global release: terminal 4 is clock
// - terminal 5 offers gpio4, low power, wake, irq
// - terminal 6 is clock run or irq
// - host speaker is xor of card inputs
// - suspend blocks register clearing by resets
// - dedicated output carries ring or power event
module mft_router
   import mft_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 nrst,
   input  wire logic                 global_reset_in,
   input  wire logic                 bus_reset_in,
   input  wire logic                 suspend_in,
   input  wire logic                 strap_in,
   input  wire logic                 route_wr,
   input  wire logic [ROUTE_W-1:0]   route_wdata,
   output logic      [ROUTE_W-1:0]   route_rdata,
   output logic                      serial_bus_active,
   output logic                      eeprom_load_start,
   input  wire logic                 sda_drive_low,
   input  wire logic                 scl_drive_low,
   input  wire mft_func_type         func,
   output mft_sense_type             sense,
   input  wire logic [NUM_PINS-1:0]  multi_pin_in,
   output logic      [NUM_PINS-1:0]  multi_pin_out,
   output logic      [NUM_PINS-1:0]  multi_pin_oe_n,
   input  wire logic [NUM_CARDS-1:0] card_speaker_in,
   input  wire logic                 ring_sel_pme,
   input  wire logic                 ring_indicate_in,
   input  wire logic                 pme_in,
   output logic                      host_speaker_out,
   output logic                      ring_out
);

   logic [ROUTE_W-1:0]  route_q;
   logic [ROUTE_W-1:0]  route_d;
   logic                serial_en_q;
   logic                global_reset_in_q;
   logic                bus_reset_in_q;
   logic                load_q;
   logic                clear_regs;
   logic [NUM_PINS-1:0] cell_drv;
   logic [NUM_PINS-1:0] cell_en;
   logic [NUM_PINS-1:0] pin_out_d;
   logic [NUM_PINS-1:0] pin_oe_n_d;
   mft_sense_type       sense_q;
   mft_sense_type       sense_d;

   // routing field of one terminal
   function automatic logic [ROLE_W-1:0] role_of(input logic [ROUTE_W-1:0] r,
                                                 input int unsigned        pin);
      role_of = r[pin*ROLE_W +: ROLE_W];
   endfunction

   // system resets clear state only when suspend is low
   // suspend blocks clearing
   assign clear_regs = (global_reset_in | bus_reset_in) & ~suspend_in;

   // software write lands unless a reset is clearing
   // routing field write
   always_comb begin
      route_d = route_q;
      if (clear_regs) begin
         route_d = ROUTE_RESET;
      end else if (route_wr) begin
         route_d = route_wdata;
      end
   end

   // routing register; reset value puts terminal 3 in serialized irq
   // serialized irq default
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         route_q <= ROUTE_RESET;
      end else begin
         route_q <= route_d;
      end
   end

   // reset level history, used to find the release edges
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         global_reset_in_q <= 1'b1;
         bus_reset_in_q <= 1'b1;
      end else begin
         global_reset_in_q <= global_reset_in;
         bus_reset_in_q <= bus_reset_in;
      end
   end

   // strap is caught on the cycle global reset falls, not under nrst,
   // so a strap pin never feeds an asynchronous load
   // strap sample
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         serial_en_q <= 1'b0;
      end else if (global_reset_in_q && !global_reset_in) begin
         serial_en_q <= ~strap_in;
      end
   end

   // one-cycle load request when bus reset releases with the loader present
   // eeprom load request
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         load_q <= 1'b0;
      end else begin
         load_q <= bus_reset_in_q & ~bus_reset_in & serial_en_q;
      end
   end

   // one selector per terminal; legality masks keep per-terminal role sets
   // role selection
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_cell
         mft_pin_cell #(.PIN(gi)) u_cell (
            .role (role_of(route_q, gi)),
            .func (func),
            .drv  (cell_drv[gi]),
            .en   (cell_en[gi])
         );
      end
   endgenerate

   // two-wire loader lines are open drain and beat the routed role
   // two-wire override
   always_comb begin
      pin_out_d  = cell_drv;
      pin_oe_n_d = ~cell_en;
      if (serial_en_q) begin
         pin_out_d[SDA_PIN]  = 1'b0;
         pin_oe_n_d[SDA_PIN] = ~sda_drive_low;
         pin_out_d[SCL_PIN]  = 1'b0;
         pin_oe_n_d[SCL_PIN] = ~scl_drive_low;
      end
   end

   // registered terminal drive; enables start released so nothing fights at power-up
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         multi_pin_out  <= '0;
         multi_pin_oe_n <= '1;
      end else begin
         multi_pin_out  <= pin_out_d;
         multi_pin_oe_n <= pin_oe_n_d;
      end
   end

   // sampled terminal levels back to internal functions; a function
   // not routed to its terminal sees its idle level instead
   always_comb begin
      sense_d = '0;
      for (int k = 0; k < NUM_GP; k++) begin
         if (role_of(route_q, GP_PIN[k]) == ROLE_GPI) begin
            sense_d.gen_input[k] = multi_pin_in[GP_PIN[k]];
         end
      end
      sense_d.lock_in        = (role_of(route_q, 4) == ROLE_LOCK) ? multi_pin_in[4] : 1'b1;
      sense_d.serialized_irq = (role_of(route_q, 3) == ROLE_SERIRQ) ? multi_pin_in[3] : 1'b1;
      sense_d.clkrun_in      = (role_of(route_q, 6) == ROLE_CLKRUN) ? multi_pin_in[6] : 1'b0;
      sense_d.sda_in = serial_en_q ? multi_pin_in[SDA_PIN] : 1'b1;
      sense_d.scl_in = serial_en_q ? multi_pin_in[SCL_PIN] : 1'b1;
   end

   // sense register; one cycle of latency keeps every output a flop
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sense_q <= '0;
      end else begin
         sense_q <= sense_d;
      end
   end

   // speaker path: xor lets either socket's tone through unchanged
   // speaker xor
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         host_speaker_out <= 1'b0;
      end else begin
         host_speaker_out <= ^card_speaker_in;
      end
   end

   // dedicated ring or power-event output
   // ring or event select
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ring_out <= 1'b0;
      end else begin
         ring_out <= ring_sel_pme ? pme_in : ring_indicate_in;
      end
   end

   // status outputs
   assign route_rdata       = route_q;
   assign serial_bus_active = serial_en_q;
   assign eeprom_load_start = load_q;
   assign sense             = sense_q;

endmodule
`default_nettype wire

// >>> src/mft_pkg.sv
// package: role codes, pin maps and reset values for the multifunction terminal router
package mft_pkg;

   localparam int unsigned NUM_PINS  = 7;
   localparam int unsigned NUM_GP    = 5;
   localparam int unsigned NUM_CARDS = 2;
   localparam int unsigned ROLE_W    = 4;
   localparam int unsigned ROUTE_W   = NUM_PINS * ROLE_W;

   // role codes held in each terminal's routing field
   localparam logic [3:0] ROLE_GPI    = 4'h0;
   localparam logic [3:0] ROLE_GPO    = 4'h1;
   localparam logic [3:0] ROLE_PINT   = 4'h2;
   localparam logic [3:0] ROLE_LED    = 4'h3;
   localparam logic [3:0] ROLE_ZV     = 4'h4;
   localparam logic [3:0] ROLE_APWM   = 4'h5;
   localparam logic [3:0] ROLE_WAKE   = 4'h6;
   localparam logic [3:0] ROLE_IRQ    = 4'h7;
   localparam logic [3:0] ROLE_RING   = 4'h8;
   localparam logic [3:0] ROLE_LOWPWR = 4'h9;
   localparam logic [3:0] ROLE_LOCK   = 4'ha;
   localparam logic [3:0] ROLE_SERIRQ = 4'hb;
   localparam logic [3:0] ROLE_CLKRUN = 4'hc;

   // legal roles per terminal, one bit per role code
   localparam logic [15:0] LEGAL_MASK [NUM_PINS] = '{
      16'h00ff,   // terminal 0
      16'h00ff,   // terminal 1
      16'h03fb,   // terminal 2: no parallel interrupt, adds ring and low power
      16'h0880,   // terminal 3: parallel irq or serialized irq
      16'h07fb,   // terminal 4: adds bus lock, ring and low power
      16'h02fb,   // terminal 5: adds low power
      16'h1080    // terminal 6: parallel irq or clock run
   };

   // general-purpose bit served by each terminal
   localparam int unsigned GP_INDEX [NUM_PINS] = '{0, 1, 2, 0, 3, 4, 0};
   // terminal carrying each general-purpose input
   localparam int unsigned GP_PIN [NUM_GP] = '{0, 1, 2, 4, 5};

   // two-wire loader terminals
   localparam int unsigned SDA_PIN = 1;
   localparam int unsigned SCL_PIN = 4;

   // routing reset value: all inputs, serialized irq on 3, clock run on 6
   localparam logic [ROUTE_W-1:0] ROUTE_RESET = 28'hc00b000;

   // internal functions offered to the terminals
   typedef struct packed {
      logic              par_int_a;
      logic              par_int_b;
      logic [NUM_GP-1:0] gen_output;
      logic              led;
      logic              video_switch_out;
      logic              card_audio_pwm;
      logic              wake_event_out;
      logic [NUM_PINS-1:0] par_irq;
      logic              ring_sig;
      logic              low_power_state_out;
      logic              serirq_out;
      logic              serirq_drive;
      logic              clkrun_out;
      logic              clkrun_drive;
   } mft_func_type;

   // terminal levels handed back to the internal functions
   typedef struct packed {
      logic [NUM_GP-1:0] gen_input;
      logic              lock_in;
      logic              serialized_irq;
      logic              clkrun_in;
      logic              sda_in;
      logic              scl_in;
   } mft_sense_type;

endpackage

// >>> src/mft_pin_cell.sv
// one terminal's output selector driven by its routing field
`timescale 1ns/1ns
`default_nettype none
module mft_pin_cell
   import mft_pkg::*;
#(
   parameter int unsigned PIN = 0
) (
   input  wire logic [ROLE_W-1:0] role,
   input  wire mft_func_type      func,
   output logic                   drv,
   output logic                   en
);

   logic legal;
   logic pint;

   // a code not offered on this terminal leaves it floating
   assign legal = LEGAL_MASK[PIN][role];
   assign pint  = (PIN == 0) ? func.par_int_a : func.par_int_b;

   // role decode; card interrupt (pint) and wake roles are open drain, low active
   always_comb begin
      drv = 1'b0;
      en  = 1'b0;
      if (legal) begin
         unique case (role)
            ROLE_GPO: begin
               drv = func.gen_output[GP_INDEX[PIN]];
               en  = 1'b1;
            end
            ROLE_PINT: en = pint;
            ROLE_LED: begin
               drv = func.led;
               en  = 1'b1;
            end
            ROLE_ZV: begin
               drv = func.video_switch_out;
               en  = 1'b1;
            end
            ROLE_APWM: begin
               drv = func.card_audio_pwm;
               en  = 1'b1;
            end
            ROLE_WAKE: en = func.wake_event_out;
            ROLE_IRQ: begin
               drv = func.par_irq[PIN];
               en  = 1'b1;
            end
            ROLE_RING: begin
               drv = func.ring_sig;
               en  = 1'b1;
            end
            ROLE_LOWPWR: begin
               drv = func.low_power_state_out;
               en  = 1'b1;
            end
            ROLE_SERIRQ: begin
               drv = func.serirq_out;
               en  = func.serirq_drive;
            end
            ROLE_CLKRUN: begin
               drv = func.clkrun_out;
               en  = func.clkrun_drive;
            end
            default: en = 1'b0;  // input roles: gpi, bus lock
         endcase
      end
   end

endmodule
`default_nettype wire

// >>> tb/mft_board.sv
// board model: pull-ups on the terminals plus an external low per pin that beats any drive
`timescale 1ns/1ns
`default_nettype none
module mft_board
   import mft_pkg::*;
(
   input  wire logic [NUM_PINS-1:0] pin_out,
   input  wire logic [NUM_PINS-1:0] pin_oe_n,
   input  wire logic [NUM_PINS-1:0] ext_low,
   output logic      [NUM_PINS-1:0] pin_level
);
   // a released pin floats high, never holds its last driven value
   assign pin_level = ~ext_low & (pin_oe_n | pin_out);
endmodule
`default_nettype wire

// >>> tb/mft_router_assertions.sv
// port checker for the terminal router
`timescale 1ns/1ns
`default_nettype none
module mft_router_assertions
   import mft_pkg::*;
(
   input wire logic                 clock,
   input wire logic                 nrst,
   input wire logic                 global_reset_in,
   input wire logic                 bus_reset_in,
   input wire logic                 suspend_in,
   input wire logic                 strap_in,
   input wire logic                 route_wr,
   input wire logic [ROUTE_W-1:0]   route_wdata,
   input wire logic [ROUTE_W-1:0]   route_rdata,
   input wire logic                 serial_bus_active,
   input wire logic                 eeprom_load_start,
   input wire logic                 sda_drive_low,
   input wire logic [NUM_PINS-1:0]  multi_pin_out,
   input wire logic [NUM_PINS-1:0]  multi_pin_oe_n,
   input wire logic [NUM_CARDS-1:0] card_speaker_in,
   input wire logic                 ring_sel_pme,
   input wire logic                 ring_indicate_in,
   input wire logic                 pme_in,
   input wire logic                 host_speaker_out,
   input wire logic                 ring_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // clearing reset seen without suspend
   logic clr;
   assign clr = (global_reset_in | bus_reset_in) & ~suspend_in;
   property p_spk;
      $past(nrst) |-> host_speaker_out == $past(^card_speaker_in);
   endproperty
   a_spk: assert property (p_spk) else $error("speaker not xor of cards");
   property p_ring;
      $past(nrst) |-> ring_out == $past(ring_sel_pme ? pme_in : ring_indicate_in);
   endproperty
   a_ring: assert property (p_ring) else $error("ring output wrong source");
   property p_strap;
      $fell(global_reset_in) |=> serial_bus_active == !$past(strap_in);
   endproperty
   a_strap: assert property (p_strap) else $error("strap sample wrong");
   property p_load;
      $fell(bus_reset_in) && serial_bus_active |=> eeprom_load_start ##1 !eeprom_load_start;
   endproperty
   a_load: assert property (p_load) else $error("load pulse missing");
   property p_cause;
      eeprom_load_start |-> $past(serial_bus_active) && $past(bus_reset_in, 2)
                            && !$past(bus_reset_in);
   endproperty
   a_cause: assert property (p_cause) else $error("load pulse without cause");
   property p_clear;
      clr |=> route_rdata == ROUTE_RESET;
   endproperty
   a_clear: assert property (p_clear) else $error("routing not cleared");
   property p_keep;
      (global_reset_in | bus_reset_in) && suspend_in && !route_wr |=> $stable(route_rdata);
   endproperty
   a_keep: assert property (p_keep) else $error("routing lost in suspend");
   property p_wr;
      route_wr && !clr |=> route_rdata == $past(route_wdata);
   endproperty
   a_wr: assert property (p_wr) else $error("routing write lost");
   property p_sda;
      $past(serial_bus_active) |-> !multi_pin_out[1] && multi_pin_oe_n[1] == !$past(sda_drive_low);
   endproperty
   a_sda: assert property (p_sda) else $error("data line not loader driven");
endmodule
`default_nettype wire

// >>> tb/test_mft_router.sv
// self-checking bench for the terminal router
`timescale 1ns/1ns
`default_nettype none
module test_mft_router;
   import mft_pkg::*;
   logic                 clock, nrst, global_reset_in, bus_reset_in, suspend_in, strap_in;
   logic                 route_wr, sda_drive_low, scl_drive_low, ring_sel_pme;
   logic                 ring_indicate_in, pme_in, serial_bus_active, eeprom_load_start;
   logic                 host_speaker_out, ring_out;
   logic [ROUTE_W-1:0]   route_wdata, route_rdata, v;
   mft_func_type         func;
   mft_sense_type        sense;
   logic [NUM_PINS-1:0]  multi_pin_in, multi_pin_out, multi_pin_oe_n, ext_low;
   logic [NUM_CARDS-1:0] card_speaker_in;
   logic [6:0]           rows [4] = '{7'h09, 7'h26, 7'h57, 7'h78};
   int                   bad_count, n_checks, n;
   mft_router mft_router_inst (
      .clock             (clock),
      .nrst              (nrst),
      .global_reset_in   (global_reset_in),
      .bus_reset_in      (bus_reset_in),
      .suspend_in        (suspend_in),
      .strap_in          (strap_in),
      .route_wr          (route_wr),
      .route_wdata       (route_wdata),
      .route_rdata       (route_rdata),
      .serial_bus_active (serial_bus_active),
      .eeprom_load_start (eeprom_load_start),
      .sda_drive_low     (sda_drive_low),
      .scl_drive_low     (scl_drive_low),
      .func              (func),
      .sense             (sense),
      .multi_pin_in      (multi_pin_in),
      .multi_pin_out     (multi_pin_out),
      .multi_pin_oe_n    (multi_pin_oe_n),
      .card_speaker_in   (card_speaker_in),
      .ring_sel_pme      (ring_sel_pme),
      .ring_indicate_in  (ring_indicate_in),
      .pme_in            (pme_in),
      .host_speaker_out  (host_speaker_out),
      .ring_out          (ring_out)
   );
   mft_board mft_board_inst (.pin_out(multi_pin_out), .pin_oe_n(multi_pin_oe_n),
      .ext_low(ext_low), .pin_level(multi_pin_in));
   // 4 ns clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // step past edges, then sample once outputs settled
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   // pins follow one cycle after the taking edge
   task automatic wr(input logic [ROUTE_W-1:0] d);
      @(posedge clock);
      route_wr <= 1'b1;
      route_wdata <= d;
      @(posedge clock);
      route_wr <= 1'b0;
      cyc(3);
   endtask
   // one-cycle global (g=1) or bus (g=0) reset pulse
   task automatic sys_rst(input logic g);
      @(posedge clock);
      global_reset_in <= g;
      bus_reset_in <= !g;
      @(posedge clock);
      global_reset_in <= 1'b0;
      bus_reset_in <= 1'b0;
      cyc(2);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // about 530 cycles expected; cut a hang well beyond that
   initial begin
      #40000;
      bad_count++;
      summarize();
   end
   initial begin
      {nrst, global_reset_in, bus_reset_in, suspend_in, route_wr} = '0;
      {sda_drive_low, scl_drive_low, ring_sel_pme, ring_indicate_in, pme_in} = '0;
      strap_in = 1'b1;
      route_wdata = '0;
      func = '0;
      ext_low = '0;
      card_speaker_in = '0;
      bad_count = 0;
      n_checks = 0;
      cyc(5);
      chk("route", ROUTE_RESET, route_rdata);
      chk("serirq role", ROLE_SERIRQ, route_rdata[4*3 +: 4]);
      chk("oe_n", 7'h7f, multi_pin_oe_n);
      @(posedge clock);
      nrst <= 1'b1;
      $display("reset test done");
      foreach (rows[i]) begin
         @(posedge clock);
         {card_speaker_in, ring_sel_pme, ring_indicate_in, pme_in} <= rows[i][6:2];
         cyc(2);
         chk("speaker", rows[i][1], host_speaker_out);
         chk("ring", rows[i][0], ring_out);
      end
      $display("row test done");
      // every role code on every terminal; open-drain roles drive low
      @(posedge clock);
      func <= '1;
      for (int p = 0; p < NUM_PINS; p++) begin
         for (int c = 0; c <= 12; c++) begin
            v = ROUTE_RESET;
            v[4*p +: 4] = c[3:0];
            wr(v);
            n = int'(LEGAL_MASK[p][c] && c != 0 && c != 10);
            chk("oe_n", !n, multi_pin_oe_n[p]);
            if (n == 1) chk("out", c != 2 && c != 6, multi_pin_out[p]);
         end
      end
      // open-drain role lets go once its function goes idle
      func <= '0;
      wr(ROUTE_RESET | 28'h0000006);
      chk("wake off", 1, multi_pin_oe_n[0]);
      $display("role test done");
      wr(ROUTE_RESET);
      for (int i = 0; i < NUM_GP; i++) begin
         @(posedge clock);
         ext_low <= ~(7'h01 << GP_PIN[i]);
         cyc(2);
         chk("gen_input", 5'h01 << i, sense.gen_input);
         chk("serirq in", 0, sense.serialized_irq);
      end
      @(posedge clock);
      ext_low <= '0;
      strap_in <= 1'b0;
      sys_rst(1'b1);
      chk("serial", 1, serial_bus_active);
      @(posedge clock);
      global_reset_in <= 1'b1;
      @(posedge clock);
      bus_reset_in <= 1'b1;
      global_reset_in <= 1'b0;
      @(posedge clock);
      bus_reset_in <= 1'b0;
      n = 0;
      repeat (4) begin
         cyc(1);
         n += int'(eeprom_load_start === 1'b1);
      end
      chk("load pulses", 1, n);
      // general outputs on 1 and 4 must lose to the loader
      sda_drive_low <= 1'b1;
      wr(ROUTE_RESET | 28'h0010010);
      chk("sda", 2'b00, {multi_pin_oe_n[1], multi_pin_out[1]});
      chk("scl oe", 1, multi_pin_oe_n[4]);
      chk("sda in", 0, sense.sda_in);
      sda_drive_low <= 1'b0;
      scl_drive_low <= 1'b1;
      cyc(3);
      chk("pins", 2'b10, {multi_pin_oe_n[1], multi_pin_oe_n[4]});
      chk("scl in", 0, sense.scl_in);
      $display("loader test done");
      scl_drive_low <= 1'b0;
      strap_in <= 1'b1;
      suspend_in <= 1'b1;
      wr(28'hcb00001);
      sys_rst(1'b1);
      chk("kept", 28'hcb00001, route_rdata);
      chk("serial", 0, serial_bus_active);
      @(posedge clock);
      suspend_in <= 1'b0;
      sys_rst(1'b0);
      chk("cleared", ROUTE_RESET, route_rdata);
      $display("suspend test done");
      summarize();
   end
endmodule
bind mft_router mft_router_assertions mft_router_assertions_inst (
   .clock             (clock),
   .nrst              (nrst),
   .global_reset_in   (global_reset_in),
   .bus_reset_in      (bus_reset_in),
   .suspend_in        (suspend_in),
   .strap_in          (strap_in),
   .route_wr          (route_wr),
   .route_wdata       (route_wdata),
   .route_rdata       (route_rdata),
   .serial_bus_active (serial_bus_active),
   .eeprom_load_start (eeprom_load_start),
   .sda_drive_low     (sda_drive_low),
   .multi_pin_out     (multi_pin_out),
   .multi_pin_oe_n    (multi_pin_oe_n),
   .card_speaker_in   (card_speaker_in),
   .ring_sel_pme      (ring_sel_pme),
   .ring_indicate_in  (ring_indicate_in),
   .pme_in            (pme_in),
   .host_speaker_out  (host_speaker_out),
   .ring_out          (ring_out)
);
`default_nettype wire
